// >>> bench/stm_ctl_model.sv
// Controller model issuing mode register writes and self-refresh requests
`timescale 1ns/1ns
`default_nettype none
module stm_ctl_model (
  input wire logic ref_clk,
  output var logic mrsValid,
  output var logic [2:0] mrsBank,
  output var logic [stm_pkg::ADDR_W-1:0] mrsAddr,
  output var logic selfRefreshReq
);
  import stm_pkg::*;
  initial begin
    mrsValid = 1'b0;
    mrsBank = 3'h0;
    mrsAddr = 14'h0000;
    selfRefreshReq = 1'b0;
  end
  // Write taken gap cycles after the previous one; idle address lines toggle
  task automatic cmd(input logic [2:0] b, input logic a, input logic r, input int gap, input logic [13:0] f);
    logic [13:0] v;
    v = f;
    v[AUTO_BIT] = a;
    v[RANGE_BIT] = r;
    repeat (gap - 1) begin
      @(posedge ref_clk);
      mrsValid <= 1'b0;
      mrsAddr <= ~mrsAddr;
    end
    @(posedge ref_clk);
    mrsValid <= 1'b1;
    mrsBank <= b;
    mrsAddr <= v;
  endtask : cmd
  task automatic done();
    @(posedge ref_clk);
    mrsValid <= 1'b0;
    mrsAddr <= ~mrsAddr;
  endtask : done
  task automatic req(input logic v);
    @(posedge ref_clk);
    selfRefreshReq <= v;
  endtask : req
endmodule : stm_ctl_model
`default_nettype wire

// >>> bench/tb_stm_selfrefresh_ctrl.sv
// Self-checking bench for the self-refresh temperature mode control
`timescale 1ns/1ns
`default_nettype none
module tb_stm_selfrefresh_ctrl;
  import stm_pkg::*;
  typedef struct {string nm; logic [15:0] v; logic [15:0] m;} stm_note_t;
  logic ref_clk, rst, tempHigh, mrsValid, selfRefreshReq, snap, d1, havePrev, ticked, curA, curR;
  logic autoQ, rangeQ, illQ, actQ, fastQ, tickQ, lpQ, rvQ, vioQ;
  logic [2:0] mrsBank;
  logic [ADDR_W-1:0] mrsAddr;
  logic [15:0] rows [7] = '{16'h0a14, 16'h0901, 16'h0b03, 16'h1404, 16'h0802, 16'h0904, 16'h0805};
  stm_note_t q[$];
  int fail_count, checks, cyc, lastTick, tickN;
  integer seed = 32'hee2f36d9;
  stm_ctl_model i_stm_ctl_model (.ref_clk(ref_clk), .mrsValid(mrsValid), .mrsBank(mrsBank), .mrsAddr(mrsAddr),
    .selfRefreshReq(selfRefreshReq));
  stm_selfrefresh_ctrl i_stm_selfrefresh_ctrl (.ref_clk(ref_clk), .rst(rst), .mrsValid(mrsValid),
    .mrsBank(mrsBank), .mrsAddr(mrsAddr), .selfRefreshReq(selfRefreshReq), .tempHigh(tempHigh),
    .autoSelfrefreshSelect_r(autoQ), .selfrefreshRangeSelect_r(rangeQ), .illegalMode_r(illQ),
    .selfRefreshActive_r(actQ), .srFastRate_r(fastQ), .refreshTick_r(tickQ), .lowPower_r(lpQ),
    .rangeViolation_r(rvQ), .mrdViolation_r(vioQ));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    if (q.size() != 0) begin
      fail_count++;
      $display("MISMATCH pending expected 0 seen %0d", q.size());
    end
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] v);
    stm_note_t n;
    checks++;
    if (q.size() == 0) begin
      fail_count++;
      $display("MISMATCH unexpected expected none seen %h", v);
    end else begin
      n = q.pop_front();
      if ((v & n.m) !== (n.v & n.m)) begin
        fail_count++;
        $display("MISMATCH %s expected %h seen %h", n.nm, n.v & n.m, v & n.m);
      end
    end
  endtask : chk
  // Watcher: mode answer one edge after a write, tick spacing, snapshots
  always @(posedge ref_clk) begin
    d1 <= mrsValid;
    cyc <= cyc + 1;
  end
  always @(negedge ref_clk) begin
    if (d1 === 1'b1) chk({autoQ, rangeQ, illQ, vioQ});
    if (selfRefreshReq !== 1'b1) begin
      havePrev = 1'b0;
      ticked = 1'b0;
    end
    if (tickQ === 1'b1) begin
      if (havePrev) chk(16'(cyc - lastTick));
      havePrev = 1'b1;
      ticked = 1'b1;
      lastTick = cyc;
      tickN++;
    end
    if (snap === 1'b1) chk({autoQ, rangeQ, illQ, actQ, fastQ, lpQ, rvQ, ticked});
  end
  task automatic note(input string s, input logic [15:0] v, input logic [15:0] m);
    q.push_back('{s, v, m});
  endtask : note
  task automatic doSnap();
    @(posedge ref_clk);
    snap <= 1'b1;
    @(posedge ref_clk);
    snap <= 1'b0;
  endtask : doSnap
  task automatic doReset(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge ref_clk);
    rst <= 1'b0;
    curA = 1'b0;
    curR = 1'b0;
    note("reset", 16'h0000, 16'h00ff);
    doSnap();
  endtask : doReset
  task automatic wr(input logic [2:0] b, input logic a, input logic r, input int gap);
    if (b == MODE_TWO_BANK) begin
      curA = a;
      curR = r;
    end
    note("mode", {curA, curR, curA & curR, 1'(gap < MRD_CYCLES)}, 16'h000f);
    i_stm_ctl_model.cmd(b, a, r, gap, 14'($random(seed)));
  endtask : wr
  task automatic sr(input logic a, input logic r, input logic hot);
    logic ill, fast;
    int t0;
    ill = a & r;
    fast = r | (a & hot);
    wr(MODE_TWO_BANK, a, r, 20);
    i_stm_ctl_model.done();
    tempHigh <= hot;
    repeat (6) @(posedge ref_clk);
    t0 = tickN;
    i_stm_ctl_model.req(1'b1);
    if (ill) begin
      repeat (250) @(posedge ref_clk);
    end else begin
      repeat (2) note("gap", 16'(fast ? EXT_CYCLES : NORM_CYCLES), 16'hffff);
      for (int k = 0; k < 700 && tickN - t0 < 3; k++) @(posedge ref_clk);
    end
    note("sr", {a, r, ill, 1'b1, fast, !fast, hot & !fast, !ill}, ill ? 16'h00f1 : 16'h00ff);
    doSnap();
    i_stm_ctl_model.req(1'b0);
    repeat (3) @(posedge ref_clk);
    note("exit", {a, r, ill, 5'h00}, 16'h00f6);
    doSnap();
  endtask : sr
  initial begin
    rst = 1'b1;
    tempHigh = 1'b0;
    snap = 1'b0;
    doReset(12);
    for (int i = 0; i < 7; i++) wr(rows[i][12:10], rows[i][9], rows[i][8], int'(rows[i][7:0]));
    i_stm_ctl_model.done();
    sr(1'b0, 1'b0, 1'b0);
    sr(1'b0, 1'b0, 1'b1);
    sr(1'b0, 1'b1, 1'b1);
    sr(1'b1, 1'b0, 1'b0);
    sr(1'b1, 1'b0, 1'b1);
    sr(1'b1, 1'b1, 1'b0);
    wr(MODE_TWO_BANK, 1'b0, 1'b1, 20);
    i_stm_ctl_model.done();
    i_stm_ctl_model.req(1'b1);
    repeat (50) @(posedge ref_clk);
    i_stm_ctl_model.req(1'b0);
    doReset(2);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end
endmodule : tb_stm_selfrefresh_ctrl
`default_nettype wire

// >>> inc/stm_pkg.sv
// Constants, types and decode helper for the self-refresh temperature mode block
// Behaviour
// [R1] Automatic self-refresh is active only after a mode register two write with auto=1, range=0.
// [R2] In automatic mode the device picks its own self-refresh rate from its temperature.
// [R3] The controller writes the auto bit as 0 on devices without automatic self-refresh.
// [R4] With auto off, the controller writes the range bit for the coming self-refresh.
// [R5] Range bit 0 with auto off gives the normal-range self-refresh rate.
// [R6] Range bit 1 with auto off gives the faster rate valid in both ranges.
// [R7] With auto on, the controller keeps the range bit 0; both set is illegal.
// [R8] Without extended-range support the controller writes range 0 and stays in normal range.
// [R9] In the extended range the controller refreshes twice as often, every 3.9 us.
// [R10] Extended-range self-refresh needs manual extended mode or automatic mode.
// [R11] The controller spaces mode register writes by the command delay.
// [R12] The self-refresh timer period follows the decoded setting; the illegal setting stops it.
package stm_pkg;
  localparam logic [2:0] MODE_TWO_BANK = 3'h2;
  localparam int AUTO_BIT = 6;
  localparam int RANGE_BIT = 7;
  localparam int ADDR_W = 14;
  localparam logic AUTO_RESET = 1'h0;
  localparam logic RANGE_RESET = 1'h0;
  localparam int CLK_PERIOD_NS = 40;
  localparam int NORM_INTERVAL_NS = 7800;
  localparam int EXT_INTERVAL_NS = 3900;
  // Longest intervals round down to whole cycles
  localparam int NORM_CYCLES = NORM_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int EXT_CYCLES = EXT_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int MRD_CYCLES = 4;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_EXT = 4'h2,
    MODE_AUTO = 4'h4,
    MODE_ILLEGAL = 4'h8
  } stm_mode_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'h1,
    SR_ACTIVE = 2'h2
  } stm_sr_state_t;

  // Decodes the two mode bits into one self-refresh mode
  function automatic stm_mode_t stm_decode(input logic autoBit, input logic rangeBit);
    stm_mode_t m;
    m = MODE_NORMAL;
    if (autoBit && rangeBit) begin
      m = MODE_ILLEGAL; // [R7]
    end else if (autoBit) begin
      m = MODE_AUTO; // [R1]
    end else if (rangeBit) begin
      m = MODE_EXT; // [R6]
    end
    return m;
  endfunction : stm_decode
endpackage : stm_pkg

// >>> inc/stm_timer_if.sv
// Link between the mode control and the self-refresh timer
`timescale 1ns/1ns
`default_nettype none
interface stm_timer_if;
  logic enable;
  logic fastRate;
  logic tick;
  modport ctl (output enable, output fastRate, input tick);
  modport tmr (input enable, input fastRate, output tick);
endinterface : stm_timer_if
`default_nettype wire

// >>> rtl/stm_selfrefresh_ctrl.sv
// Mode register two self-refresh temperature mode control
`timescale 1ns/1ns
`default_nettype none
module stm_selfrefresh_ctrl #(
  parameter bit AUTO_SUPPORTED = 1'b1,
  parameter bit EXT_SUPPORTED = 1'b1,
  parameter int MRD_CNT = stm_pkg::MRD_CYCLES,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mrsValid,
  input wire logic [2:0] mrsBank,
  input wire logic [stm_pkg::ADDR_W-1:0] mrsAddr,
  input wire logic selfRefreshReq,
  input wire logic tempHigh,
  output var logic autoSelfrefreshSelect_r,
  output var logic selfrefreshRangeSelect_r,
  output var logic illegalMode_r,
  output var logic selfRefreshActive_r,
  output var logic srFastRate_r,
  output var logic refreshTick_r,
  output var logic lowPower_r,
  output var logic rangeViolation_r,
  output var logic mrdViolation_r
);
  import stm_pkg::*;

  generate
    if (MRD_CNT < 1 || MRD_CNT > 255) begin : g_bad_mrd
      $error("mode register delay out of range");
    end
  endgenerate

  stm_timer_if tif ();

  stm_sr_timer #(
    .NORM_CNT(NORM_CYCLES),
    .EXT_CNT(EXT_CYCLES),
    .CNT_W(CNT_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .tif(tif)
  );

  logic tempMeta_r;
  logic tempSync_r;
  logic modeTwoWrite;
  logic autoBitIn;
  logic rangeBitIn;
  stm_mode_t mode_r;
  stm_mode_t modeIn;
  stm_sr_state_t srState_r;
  stm_sr_state_t srState_nxt;
  logic timerEn_r;
  logic fast_nxt;
  logic [7:0] mrdCnt_r;

  // Temperature pin crosses in through two flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tempMeta_r <= 1'b0;
      tempSync_r <= 1'b0;
    end else begin
      tempMeta_r <= tempHigh;
      tempSync_r <= tempMeta_r;
    end
  end

  assign modeTwoWrite = mrsValid && (mrsBank == MODE_TWO_BANK);
  // An unsupported auto option reads back as 0; the range bit is stored as written
  assign autoBitIn = AUTO_SUPPORTED && mrsAddr[AUTO_BIT];
  assign rangeBitIn = mrsAddr[RANGE_BIT];
  assign modeIn = stm_decode(autoBitIn, rangeBitIn);

  // Mode register two fields and decoded mode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      autoSelfrefreshSelect_r <= AUTO_RESET;
      selfrefreshRangeSelect_r <= RANGE_RESET;
      mode_r <= MODE_NORMAL;
      illegalMode_r <= 1'b0;
    end else if (modeTwoWrite) begin
      autoSelfrefreshSelect_r <= autoBitIn; // [R1]
      selfrefreshRangeSelect_r <= rangeBitIn; // [R4]
      mode_r <= modeIn; // [R12]
      illegalMode_r <= (modeIn == MODE_ILLEGAL); // [R7]
    end
  end

  // Spacing guard between mode register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mrdCnt_r <= 8'h00;
      mrdViolation_r <= 1'b0;
    end else begin
      mrdViolation_r <= mrsValid && (mrdCnt_r != 8'h00); // [R11]
      if (mrsValid) begin
        mrdCnt_r <= 8'(MRD_CNT - 1);
      end else if (mrdCnt_r != 8'h00) begin
        mrdCnt_r <= mrdCnt_r - 8'h01;
      end
    end
  end

  // Self-refresh entry and exit
  always_comb begin
    srState_nxt = srState_r;
    unique case (srState_r)
      SR_IDLE: begin
        if (selfRefreshReq) begin
          srState_nxt = SR_ACTIVE;
        end
      end
      SR_ACTIVE: begin
        if (!selfRefreshReq) begin
          srState_nxt = SR_IDLE;
        end
      end
      default: begin
        srState_nxt = SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      srState_r <= SR_IDLE;
    end else begin
      srState_r <= srState_nxt;
    end
  end

  // Rate choice from the decoded mode
  always_comb begin
    fast_nxt = 1'b0;
    unique case (mode_r)
      MODE_NORMAL: fast_nxt = 1'b0; // [R5]
      MODE_EXT: fast_nxt = EXT_SUPPORTED; // [R6]
      MODE_AUTO: fast_nxt = EXT_SUPPORTED && tempSync_r; // [R2]
      MODE_ILLEGAL: fast_nxt = 1'b0;
      default: fast_nxt = 1'b0;
    endcase
  end

  // Timer control and status outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timerEn_r <= 1'b0;
      srFastRate_r <= 1'b0;
      selfRefreshActive_r <= 1'b0;
      lowPower_r <= 1'b0;
      rangeViolation_r <= 1'b0;
    end else begin
      timerEn_r <= (srState_nxt == SR_ACTIVE) && (mode_r != MODE_ILLEGAL); // [R12]
      srFastRate_r <= fast_nxt;
      selfRefreshActive_r <= (srState_nxt == SR_ACTIVE);
      lowPower_r <= (srState_nxt == SR_ACTIVE) && !fast_nxt; // [R2]
      rangeViolation_r <= (srState_r == SR_ACTIVE) && tempSync_r && !fast_nxt; // [R8]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      refreshTick_r <= 1'b0;
    end else begin
      refreshTick_r <= tif.tick;
    end
  end

  assign tif.enable = timerEn_r;
  assign tif.fastRate = srFastRate_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_autoWrite;
    modeTwoWrite && mrsAddr[AUTO_BIT] && !mrsAddr[RANGE_BIT];
  endsequence
  sequence s_illegalWrite;
    modeTwoWrite && mrsAddr[AUTO_BIT] && mrsAddr[RANGE_BIT];
  endsequence
  sequence s_holdIdle;
    !mrsValid && !selfRefreshReq;
  endsequence
  sequence s_srEnter;
    selfRefreshReq && !selfRefreshActive_r;
  endsequence

  a_auto_mode_entry: assert property ( // [R1]
    s_autoWrite |=> (autoSelfrefreshSelect_r == AUTO_SUPPORTED) && !illegalMode_r)
    else $error("automatic mode not taken from write");
  a_illegal_combo: assert property ( // [R12]
    (s_illegalWrite ##1 s_holdIdle) |-> (illegalMode_r == AUTO_SUPPORTED) ##1 (!timerEn_r || !AUTO_SUPPORTED))
    else $error("illegal setting not flagged or timer ran");
  a_illegal_timer_off: assert property (illegalMode_r |=> !timerEn_r) // [R12]
    else $error("timer enabled in the illegal setting");
  a_illegal_no_tick: assert property (illegalMode_r [*2] |=> !tif.tick) // [R12]
    else $error("refresh event in the illegal setting");
  a_normal_rate: assert property ((mode_r == MODE_NORMAL) && selfRefreshReq |=> !srFastRate_r && timerEn_r) // [R5]
    else $error("normal mode used the fast rate");
  a_ext_rate: assert property ( // [R6]
    (mode_r == MODE_EXT) && selfRefreshReq && !modeTwoWrite |=> srFastRate_r == EXT_SUPPORTED)
    else $error("extended mode missed the fast rate");
  a_range_store: assert property (modeTwoWrite |=> selfrefreshRangeSelect_r == $past(mrsAddr[RANGE_BIT])) // [R4]
    else $error("range bit not stored from write");
  a_auto_temp: assert property ( // [R2]
    ((mode_r == MODE_AUTO) && tempHigh && !modeTwoWrite)[*3] |=> srFastRate_r == EXT_SUPPORTED)
    else $error("automatic mode ignored a hot device");
  a_auto_cool: assert property ( // [R2]
    ((mode_r == MODE_AUTO) && !tempHigh && selfRefreshReq && !modeTwoWrite)[*3] |=> !srFastRate_r && lowPower_r)
    else $error("automatic mode kept the fast rate when cool");
  a_sr_entry: assert property (s_srEnter |=> selfRefreshActive_r) // [R2]
    else $error("self-refresh request not taken");
  a_sr_exit: assert property (!selfRefreshReq |=> !selfRefreshActive_r && !timerEn_r) // [R12]
    else $error("self-refresh kept after request dropped");
  a_low_power: assert property (lowPower_r == (selfRefreshActive_r && !srFastRate_r)) // [R2]
    else $error("low power flag does not follow the rate");
  a_range_flag: assert property ( // [R8]
    selfRefreshActive_r && tempSync_r && (mode_r == MODE_NORMAL) |=> rangeViolation_r)
    else $error("hot device at normal rate not flagged");
  a_tick_forward: assert property (tif.tick |=> refreshTick_r) // [R12]
    else $error("refresh event not passed out");
  a_mrd_guard: assert property (mrsValid ##1 mrsValid |=> mrdViolation_r == (MRD_CNT > 1)) // [R11]
    else $error("mode register spacing not checked");
endmodule : stm_selfrefresh_ctrl
`default_nettype wire

// >>> rtl/stm_sr_timer.sv
// Self-refresh interval timer with two selectable periods
`timescale 1ns/1ns
`default_nettype none
module stm_sr_timer #(
  parameter int NORM_CNT = stm_pkg::NORM_CYCLES,
  parameter int EXT_CNT = stm_pkg::EXT_CYCLES,
  parameter int CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  stm_timer_if.tmr tif
);
  import stm_pkg::*;

  localparam int ExtMax = EXT_CNT;
  localparam int NormMax = NORM_CNT;

  generate
    if (NORM_CNT < 2 || EXT_CNT < 2 || NORM_CNT >= (1 << CNT_W) || EXT_CNT >= (1 << CNT_W)) begin : g_bad
      $error("timer counts do not fit the counter");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;
  logic tick_r;

  assign limit = tif.fastRate ? CNT_W'(EXT_CNT - 1) : CNT_W'(NORM_CNT - 1); // [R12]
  assign tif.tick = tick_r;

  // Interval counter, restarted whenever the timer is off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (!tif.enable || cnt_r >= limit) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // One refresh pulse per elapsed interval
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tif.enable && (cnt_r >= limit); // [R12]
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_tick_single_pulse: assert property (tick_r |=> !tick_r) // [R12]
    else $error("refresh tick longer than one cycle");
  a_tick_fast_period: assert property (
    (tick_r && tif.enable && tif.fastRate) |-> ##[1:ExtMax] (tick_r || !tif.enable || !tif.fastRate)) // [R6]
    else $error("fast self-refresh interval too long");
  a_tick_norm_period: assert property (
    (tick_r && tif.enable && !tif.fastRate) |-> ##[1:NormMax] (tick_r || !tif.enable || tif.fastRate)) // [R5]
    else $error("normal self-refresh interval too long");
endmodule : stm_sr_timer
`default_nettype wire
